// File: flr_spm_ctrl.sv
// fuse and lock readback with timed self-programming control behind an AXI4-Lite slave
// Function
// - pointer 0x0001, lock-set and store-enable armed: load within three cycles returns lock byte
// - lock-set and store-enable auto-clear on readback done or window expiry
// - with lock-set and store-enable clear, a load is an ordinary flash byte read
// - lock byte: boot lock bits at 5:2, general lock bits at 1:0
// - pointer 0x0000 armed: load within three cycles returns fuse low byte
// - pointer 0x0003 armed: load within three cycles returns fuse high byte
// - programmed bits read 0, unprogrammed bits read 1
// - flash write in progress completes even across system reset
// - flash write duration counted on the calibrated rc oscillator
// - each erase, write or lock write lasts 3.7 ms to 4.5 ms
// - store within four cycles with lock-set programs boot lock bits whose source bit is zero
//
// The register offsets and the AXI4-Lite register port were left to the implementer.
`default_nettype none
`include "flr_regs.svh"
module flr_spm_ctrl #(
  parameter int unsigned ADDR_W     = 8,
  parameter int unsigned RC_KHZ     = 1000,
  parameter int unsigned PROG_TICKS = int'((`FLR_PROG_MIN_NS * 64'(RC_KHZ) + 64'd999999) / 64'd1000000)
) (
  // clock, resets and enable
  input  wire logic              MCLK_I,
  input  wire logic              RESET_N_I,
  input  wire logic              PWR_RESET_N_I,
  input  wire logic              CE_I,
  // axi4-lite write channels
  input  wire logic              AXI_AWVALID_I,
  output logic                   AXI_AWREADY_O,
  input  wire logic [ADDR_W-1:0] AXI_AWADDR_I,
  input  wire logic [2:0]        AXI_AWPROT_I,
  input  wire logic              AXI_WVALID_I,
  output logic                   AXI_WREADY_O,
  input  wire logic [31:0]       AXI_WDATA_I,
  input  wire logic [3:0]        AXI_WSTRB_I,
  output logic                   AXI_BVALID_O,
  input  wire logic              AXI_BREADY_I,
  output logic [1:0]             AXI_BRESP_O,
  // axi4-lite read channels
  input  wire logic              AXI_ARVALID_I,
  output logic                   AXI_ARREADY_O,
  input  wire logic [ADDR_W-1:0] AXI_ARADDR_I,
  input  wire logic [2:0]        AXI_ARPROT_I,
  output logic                   AXI_RVALID_O,
  input  wire logic              AXI_RREADY_I,
  output logic [31:0]            AXI_RDATA_O,
  output logic [1:0]             AXI_RRESP_O,
  // non-volatile cell state pins, high means programmed, then the rc oscillator input
  input  wire logic [7:0]        FUSE_LOW_PGM_I,
  input  wire logic [7:0]        FUSE_HIGH_PGM_I,
  input  wire logic [5:0]        LOCK_PGM_I,
  input  wire logic              RC_OSC_I,
  // core side
  input  wire logic              EEPROM_WRITE_ACTIVE_I,
  input  wire logic [7:0]        FLASH_DATA_I,
  output logic                   FLASH_RD_O,
  output logic [15:0]            FLASH_ADDR_O,
  output logic                   FLASH_BUSY_O,
  output flr_pkg::flr_kind_t     FLASH_OP_KIND_O,
  output logic [7:0]             LOCK_BITS_O
);
  import flr_pkg::*;

  localparam logic [23:0] PROG_LAST = 24'(PROG_TICKS - 1);

  // configuration byte chosen by the pointer
  function automatic logic [7:0] cfg_byte(input logic [15:0] ptr, input logic [7:0] lock,
                                          input logic [7:0] flo, input logic [7:0] fhi);
    if (ptr == `FLR_PTR_LOCK) cfg_byte = {2'h3, lock[5:0]};
    else if (ptr == `FLR_PTR_FUSE_HIGH) cfg_byte = fhi;
    else cfg_byte = flo;
  endfunction

  // register offset decode, shared by both channels
  function automatic logic reg_hit(input logic [7:0] off);
    reg_hit = (off == `FLR_ADDR_CTRL) || (off == `FLR_ADDR_PTR) || (off == `FLR_ADDR_CMD) ||
              (off == `FLR_ADDR_RESULT) || (off == `FLR_ADDR_STATUS);
  endfunction

  logic                 rst_sys;
  logic                 awr_rdy_q, awr_rdy_d, bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
  logic [1:0]           bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0]          rdata_q, rdata_d;
  logic [`FLR_CTRL_W-1:0] ctrl_q, ctrl_d;
  logic [2:0]           win_q, win_d;
  logic [15:0]          ptr_q, ptr_d, addr_q, addr_d;
  logic                 rww_busy_q, rww_busy_d, rd_q, rd_d;
  logic [7:0]           res_q, res_d;
  logic                 res_valid_q, res_valid_d, res_cfg_q, res_cfg_d;
  flr_op_t              op_q, op_d;
  flr_kind_t            kind_q, kind_d;
  logic [23:0]          cnt_q, cnt_d;
  logic [7:0]           src_q, src_d, lock_q, lock_d;
  logic [1:0]           fill_q, fill_d;
  logic [7:0]           flo_s1_q, flo_s2_q, fhi_s1_q, fhi_s2_q;
  logic [5:0]           lk_s1_q, lk_s2_q;
  logic                 rc_s1_q, rc_s2_q, rc_s3_q;
  logic [7:0]           aw_off, ar_off, flo_rd, fhi_rd;
  logic                 wr_acc, rd_acc, ctrl_wr, cmd_wr, load_req, store_req;
  logic                 cfg_load, store_go, op_start, op_end, rc_tick;

  assign rst_sys = !RESET_N_I || !PWR_RESET_N_I;
  assign aw_off  = AXI_AWADDR_I[7:0];
  assign ar_off  = AXI_ARADDR_I[7:0];
  // cells report programmed as high, readback inverts them
  // programmed reads zero
  assign flo_rd  = ~flo_s2_q;
  assign fhi_rd  = ~fhi_s2_q;
  // rc edge taken from the second and third stages, never the first
  // rc oscillator timebase
  assign rc_tick = rc_s2_q && !rc_s3_q;

  // request decode; address and data are taken together in one cycle
  assign wr_acc    = awr_rdy_q && AXI_AWVALID_I && AXI_WVALID_I;
  assign rd_acc    = arready_q && AXI_ARVALID_I;
  // an eeprom write or running flash op locks out control writes
  assign ctrl_wr   = wr_acc && (aw_off == `FLR_ADDR_CTRL) && AXI_WSTRB_I[0] &&
                     !EEPROM_WRITE_ACTIVE_I && (op_q == FLR_OP_IDLE);
  assign cmd_wr    = wr_acc && (aw_off == `FLR_ADDR_CMD) && AXI_WSTRB_I[0];
  assign load_req  = cmd_wr && AXI_WDATA_I[`FLR_CMD_LOAD];
  assign store_req = cmd_wr && AXI_WDATA_I[`FLR_CMD_STORE] && !AXI_WDATA_I[`FLR_CMD_LOAD];
  assign cfg_load  = load_req && ctrl_q[`FLR_CTRL_SPE] && ctrl_q[`FLR_CTRL_LOCKSET] &&
                     (win_q >= `FLR_WIN_LOAD_MIN);
  assign store_go  = store_req && ctrl_q[`FLR_CTRL_SPE] && (win_q != 3'h0) && !EEPROM_WRITE_ACTIVE_I;
  assign op_start  = store_go && (ctrl_q[`FLR_CTRL_LOCKSET] || ctrl_q[`FLR_CTRL_ERASE] ||
                     ctrl_q[`FLR_CTRL_WRITE]);
  assign op_end    = (op_q == FLR_OP_RUN) && rc_tick && (cnt_q == PROG_LAST);

  // bus slave next state; one write and one read in flight
  always_comb begin
    awr_rdy_d = awr_rdy_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    arready_d = arready_q;
    rvalid_d  = rvalid_q;
    rresp_d   = rresp_q;
    rdata_d   = rdata_q;
    if (wr_acc) begin
      awr_rdy_d = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = reg_hit(aw_off) ? `FLR_RESP_OKAY : `FLR_RESP_SLVERR;
    end else if (bvalid_q && AXI_BREADY_I) begin
      bvalid_d  = 1'b0;
      awr_rdy_d = 1'b1;
    end
    if (rd_acc) begin
      arready_d = 1'b0;
      rvalid_d  = 1'b1;
      rresp_d   = reg_hit(ar_off) ? `FLR_RESP_OKAY : `FLR_RESP_SLVERR;
      unique case (ar_off)
        `FLR_ADDR_CTRL:   rdata_d = {24'h0, 1'b0, rww_busy_q, 1'b0, ctrl_q};
        `FLR_ADDR_PTR:    rdata_d = {16'h0, ptr_q};
        `FLR_ADDR_RESULT: rdata_d = {22'h0, res_cfg_q, res_valid_q, res_q};
        `FLR_ADDR_STATUS: rdata_d = {16'h0, lock_q, 6'h0, EEPROM_WRITE_ACTIVE_I, op_q == FLR_OP_RUN};
        default:          rdata_d = 32'h0;
      endcase
    end else if (rvalid_q && AXI_RREADY_I) begin
      rvalid_d  = 1'b0;
      arready_d = 1'b1;
    end
  end

  // bus slave registers
  always_ff @(posedge MCLK_I) begin
    if (rst_sys) begin
      awr_rdy_q <= 1'b1;
      bvalid_q  <= 1'b0;
      bresp_q   <= `FLR_RESP_OKAY;
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rresp_q   <= `FLR_RESP_OKAY;
      rdata_q   <= 32'h0;
    end else if (CE_I) begin
      awr_rdy_q <= awr_rdy_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      arready_q <= arready_d;
      rvalid_q  <= rvalid_d;
      rresp_q   <= rresp_d;
      rdata_q   <= rdata_d;
    end
  end

  // control, window, pointer and readback next state
  always_comb begin
    ctrl_d      = ctrl_q;
    win_d       = (win_q != 3'h0) ? win_q - 3'h1 : 3'h0;
    ptr_d       = ptr_q;
    addr_d      = addr_q;
    rww_busy_d  = rww_busy_q;
    rd_d        = 1'b0;
    res_d       = res_q;
    res_valid_d = res_valid_q;
    res_cfg_d   = res_cfg_q;
    if (wr_acc && (aw_off == `FLR_ADDR_PTR)) begin
      if (AXI_WSTRB_I[0]) ptr_d[7:0] = AXI_WDATA_I[7:0];
      if (AXI_WSTRB_I[1]) ptr_d[15:8] = AXI_WDATA_I[15:8];
    end
    if (ctrl_wr) begin
      ctrl_d = AXI_WDATA_I[`FLR_CTRL_W-1:0];
      win_d  = AXI_WDATA_I[`FLR_CTRL_SPE] ? `FLR_WIN_START : 3'h0;
    end else if (cfg_load) begin
      res_d       = cfg_byte(ptr_q, lock_q, flo_rd, fhi_rd);
      res_valid_d = 1'b1;
      res_cfg_d   = 1'b1;
      ctrl_d[`FLR_CTRL_SPE]     = 1'b0;
      ctrl_d[`FLR_CTRL_LOCKSET] = 1'b0;
      win_d = 3'h0;
    end else if (load_req) begin
      rd_d        = 1'b1;
      addr_d      = ptr_q;
      res_valid_d = 1'b0;
    end else if (store_go) begin
      win_d = 3'h0;
      if (op_start) begin
        addr_d = ptr_q;
        if (!ctrl_q[`FLR_CTRL_LOCKSET]) rww_busy_d = 1'b1;
      end else begin
        // read-enable or page-load store frees the rww section
        ctrl_d     = `FLR_CTRL_RST;
        rww_busy_d = 1'b0;
      end
    end
    // clear on window expiry; a late load that became a plain read must not leave it armed
    if (!ctrl_wr && !store_go && win_q == 3'h1 && op_q == FLR_OP_IDLE) ctrl_d = `FLR_CTRL_RST;
    // a finished flash op drops store-enable so software polling sees it
    if (op_end) ctrl_d = `FLR_CTRL_RST;
    if (rd_q) begin
      res_d       = FLASH_DATA_I;
      res_valid_d = 1'b1;
      res_cfg_d   = 1'b0;
    end
  end

  // control registers, cleared by either reset; rww_busy_q survives a system reset under a running op
  always_ff @(posedge MCLK_I) begin
    if (rst_sys) begin
      ctrl_q      <= `FLR_CTRL_RST;
      win_q       <= 3'h0;
      ptr_q       <= 16'h0;
      addr_q      <= 16'h0;
      // a flash op that outlives a system reset keeps its section blocked
      rww_busy_q  <= PWR_RESET_N_I && (op_q == FLR_OP_RUN) && rww_busy_q;
      rd_q        <= 1'b0;
      res_q       <= 8'h0;
      res_valid_q <= 1'b0;
      res_cfg_q   <= 1'b0;
    end else if (CE_I) begin
      ctrl_q      <= ctrl_d;
      win_q       <= win_d;
      ptr_q       <= ptr_d;
      addr_q      <= addr_d;
      rww_busy_q  <= rww_busy_d;
      rd_q        <= rd_d;
      res_q       <= res_d;
      res_valid_q <= res_valid_d;
      res_cfg_q   <= res_cfg_d;
    end
  end

  // flash op sequencer and lock image next state
  always_comb begin
    op_d     = op_q;
    kind_d   = kind_q;
    cnt_d    = cnt_q;
    src_d    = src_q;
    lock_d   = lock_q;
    fill_d   = (fill_q == 2'h3) ? fill_q : fill_q + 2'h1;
    // lock image follows the synchroniser until its stages hold the pins, then stays put
    if (fill_q != 2'h3) lock_d = {2'h3, ~lk_s2_q};
    unique case (op_q)
      FLR_OP_IDLE: begin
        if (op_start) begin
          op_d   = FLR_OP_RUN;
          cnt_d  = 24'h0;
          src_d  = AXI_WSTRB_I[1] ? AXI_WDATA_I[15:8] : 8'hff;
          kind_d = ctrl_q[`FLR_CTRL_LOCKSET] ? FLR_KIND_LOCK :
                   ctrl_q[`FLR_CTRL_ERASE] ? FLR_KIND_ERASE : FLR_KIND_WRITE;
        end
      end
      FLR_OP_RUN: begin
        if (rc_tick) begin
          if (cnt_q == PROG_LAST) begin
            op_d = FLR_OP_IDLE;
            // program boot lock bits whose source bit is zero
            if (kind_q == FLR_KIND_LOCK) lock_d[5:2] = lock_q[5:2] & src_q[5:2];
          end else begin
            cnt_d = cnt_q + 24'h1;
          end
        end
      end
    endcase
  end

  // sequencer registers; only power reset stops a running op
  always_ff @(posedge MCLK_I) begin
    if (!PWR_RESET_N_I) begin
      op_q     <= FLR_OP_IDLE;
      kind_q   <= FLR_KIND_LOCK;
      cnt_q    <= 24'h0;
      src_q    <= 8'hff;
      lock_q   <= 8'hff;
      fill_q   <= 2'h0;
      flo_s1_q <= 8'h0;
      flo_s2_q <= 8'h0;
      fhi_s1_q <= 8'h0;
      fhi_s2_q <= 8'h0;
      lk_s1_q  <= 6'h0;
      lk_s2_q  <= 6'h0;
      rc_s1_q  <= 1'b0;
      rc_s2_q  <= 1'b0;
      rc_s3_q  <= 1'b0;
    end else if (CE_I) begin
      op_q     <= op_d;
      kind_q   <= kind_d;
      cnt_q    <= cnt_d;
      src_q    <= src_d;
      lock_q   <= lock_d;
      fill_q   <= fill_d;
      flo_s1_q <= FUSE_LOW_PGM_I;
      flo_s2_q <= flo_s1_q;
      fhi_s1_q <= FUSE_HIGH_PGM_I;
      fhi_s2_q <= fhi_s1_q;
      lk_s1_q  <= LOCK_PGM_I;
      lk_s2_q  <= lk_s1_q;
      rc_s1_q  <= RC_OSC_I;
      rc_s2_q  <= rc_s1_q;
      rc_s3_q  <= rc_s2_q;
    end
  end

  // outputs straight from flip-flops
  assign AXI_AWREADY_O   = awr_rdy_q;
  assign AXI_WREADY_O    = awr_rdy_q;
  assign AXI_BVALID_O    = bvalid_q;
  assign AXI_BRESP_O     = bresp_q;
  assign AXI_ARREADY_O   = arready_q;
  assign AXI_RVALID_O    = rvalid_q;
  assign AXI_RDATA_O     = rdata_q;
  assign AXI_RRESP_O     = rresp_q;
  assign FLASH_RD_O      = rd_q;
  assign FLASH_ADDR_O    = addr_q;
  assign FLASH_BUSY_O    = op_q;
  assign FLASH_OP_KIND_O = kind_q;
  assign LOCK_BITS_O     = lock_q;

  // independent tally of rc ticks under a running op, so the length check does not lean on cnt_q
  logic [23:0] tally_q, tally_d;
  always_comb begin
    tally_d = (op_q == FLR_OP_IDLE) ? 24'h0 : tally_q + 24'(rc_tick);
  end
  always_ff @(posedge MCLK_I) begin
    if (!PWR_RESET_N_I) begin
      tally_q <= 24'h0;
    end else if (CE_I) begin
      tally_q <= tally_d;
    end
  end

  // checks on the timed window, readback and flash op
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!PWR_RESET_N_I);

  a_win_arm_start: assert property (RESET_N_I && CE_I && ctrl_wr && AXI_WDATA_I[0] |=> win_q == 3'h4)
    else $error("window not armed at four");
  a_lock_read_back: assert property (RESET_N_I && CE_I && cfg_load && ptr_q == 16'h0001 |=>
      res_q == {2'h3, lock_q[5:0]} && res_cfg_q && !ctrl_q[0] && !ctrl_q[3])
    else $error("lock byte readback wrong");
  a_fuse_low_read: assert property (RESET_N_I && CE_I && cfg_load && ptr_q == 16'h0000 |=>
      res_q == ~$past(flo_s2_q))
    else $error("fuse low readback wrong");
  a_fuse_high_read: assert property (RESET_N_I && CE_I && cfg_load && ptr_q == 16'h0003 |=>
      res_q == ~$past(fhi_s2_q))
    else $error("fuse high readback wrong");
  a_win_expiry_clear: assert property (RESET_N_I && CE_I && win_q == 3'h1 && !ctrl_wr && !store_go &&
      !op_end && op_q == FLR_OP_IDLE |=> ctrl_q == 5'h00)
    else $error("store-enable not cleared on expiry");
  a_plain_load_read: assert property (RESET_N_I && CE_I && load_req && !ctrl_q[3] && !ctrl_q[0] && !ctrl_wr |=>
      FLASH_RD_O && FLASH_ADDR_O == $past(ptr_q) ##1 !res_cfg_q)
    else $error("plain load did not read flash");
  a_op_survives_reset: assert property (op_q == FLR_OP_RUN && !op_end && !RESET_N_I && CE_I |=>
      op_q == FLR_OP_RUN)
    else $error("flash op aborted by system reset");
  a_op_rc_paced: assert property (op_q == FLR_OP_RUN && !rc_tick |=> $stable(cnt_q) || op_q == FLR_OP_IDLE)
    else $error("op counter moved without rc tick");
  a_op_full_length: assert property (CE_I && op_end |-> tally_q == PROG_LAST)
    else $error("flash op ended early");
  a_lock_program_bits: assert property (CE_I && op_end && kind_q == FLR_KIND_LOCK |=>
      lock_q[5:2] == ($past(lock_q[5:2]) & $past(src_q[5:2])))
    else $error("boot lock bits not programmed");

endmodule // flr_spm_ctrl
`default_nettype wire

// File: flr_regs.svh
// register offsets, field positions, reset values and timing figures of the fuse/lock readback block
`ifndef FLR_REGS_SVH
`define FLR_REGS_SVH

// register byte offsets on the AXI4-Lite slave
`define FLR_ADDR_CTRL     8'h00
`define FLR_ADDR_PTR      8'h04
`define FLR_ADDR_CMD      8'h08
`define FLR_ADDR_RESULT   8'h0c
`define FLR_ADDR_STATUS   8'h10

// prog_mem_ctrl_reg fields
`define FLR_CTRL_SPE      0
`define FLR_CTRL_ERASE    1
`define FLR_CTRL_WRITE    2
`define FLR_CTRL_LOCKSET  3
`define FLR_CTRL_RWWRE    4
`define FLR_CTRL_W        5
`define FLR_CTRL_RST      5'h00

// command register fields
`define FLR_CMD_LOAD      0
`define FLR_CMD_STORE     1

// pointer values that select a configuration byte
`define FLR_PTR_FUSE_LOW  16'h0000
`define FLR_PTR_LOCK      16'h0001
`define FLR_PTR_FUSE_HIGH 16'h0003

// timed window: store allowed while counter >= 1, load while >= 2
`define FLR_WIN_START     3'h4
`define FLR_WIN_LOAD_MIN  3'h2

// flash write duration limits in ns, counted on the rc oscillator
`define FLR_PROG_MIN_NS   64'd3700000
`define FLR_PROG_MAX_NS   64'd4500000

// bus responses
`define FLR_RESP_OKAY     2'h0
`define FLR_RESP_SLVERR   2'h2

`endif

// File: flr_pkg.sv
// types shared by the fuse/lock readback block
`default_nettype none
package flr_pkg;
  // timed flash operation sequencer
  typedef enum logic [0:0] {
    FLR_OP_IDLE = 1'b0,
    FLR_OP_RUN  = 1'b1
  } flr_op_t;
  // kind of timed flash operation
  typedef enum logic [1:0] {
    FLR_KIND_LOCK  = 2'b00,
    FLR_KIND_ERASE = 2'b01,
    FLR_KIND_WRITE = 2'b10
  } flr_kind_t;
endpackage : flr_pkg
`default_nettype wire

// File: flr_cpu_model.sv
// bus master model of the cpu core running the boot loader sequences
`default_nettype none
`include "flr_regs.svh"
module flr_cpu_model (
  // clock
  input  wire logic        clk_i,
  // write channels
  output logic             awvalid_o,
  input  wire logic        awready_i,
  output logic [7:0]       awaddr_o,
  output logic [2:0]       awprot_o,
  output logic             wvalid_o,
  input  wire logic        wready_i,
  output logic [31:0]      wdata_o,
  output logic [3:0]       wstrb_o,
  input  wire logic        bvalid_i,
  input  wire logic [1:0]  bresp_i,
  // read channels
  output logic             arvalid_o,
  input  wire logic        arready_i,
  output logic [7:0]       araddr_o,
  output logic [2:0]       arprot_o,
  input  wire logic        rvalid_i,
  input  wire logic [31:0] rdata_i,
  input  wire logic [1:0]  rresp_i
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle bus at time zero
  initial begin
    {awvalid_o, wvalid_o, arvalid_o, awaddr_o, araddr_o, awprot_o, arprot_o, wdata_o, wstrb_o} = '0;
  end

  // one write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
    awvalid_o <= 1'b1;
    wvalid_o  <= 1'b1;
    awaddr_o  <= a;
    wdata_o   <= d;
    wstrb_o   <= s;
    awprot_o  <= 3'($urandom);
    do @(posedge clk_i); while (!(awready_i && wready_i));
    awvalid_o <= 1'b0;
    wvalid_o  <= 1'b0;
    do @(posedge clk_i); while (!bvalid_i);
    r = bresp_i;
  endtask

  // one read; bready and rready stay high, so the answer edge ends it
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    arvalid_o <= 1'b1;
    araddr_o  <= a;
    arprot_o  <= 3'($urandom);
    do @(posedge clk_i); while (!arready_i);
    arvalid_o <= 1'b0;
    do @(posedge clk_i); while (!rvalid_i);
    d = rdata_i;
    r = rresp_i;
  endtask

  // guarded control write followed by a load or store command
  task automatic do_spm(input logic [7:0] ctrl, input logic [15:0] cmd);
    logic [31:0] v;
    logic [1:0]  r;
    do rd(`FLR_ADDR_CTRL, v, r); while (v[0] !== 1'b0);
    do rd(`FLR_ADDR_STATUS, v, r); while (v[1] !== 1'b0);
    // pair kept atomic: nothing may slip between the two writes
    wr(`FLR_ADDR_CTRL, {24'h0, ctrl}, 4'hf, r);
    wr(`FLR_ADDR_CMD, {16'h0, cmd}, 4'hf, r);
  endtask

  // repeat read-enable store while section busy
  task automatic rww_return();
    logic [31:0] v;
    logic [1:0]  r;
    forever begin
      rd(`FLR_ADDR_CTRL, v, r);
      if (v[6] !== 1'b1) break;
      do_spm(8'h11, 16'hff02);
    end
  endtask
endmodule // flr_cpu_model
`default_nettype wire

// File: tb_top.sv
// self-checking bench of the fuse/lock readback block
`default_nettype none
`include "flr_regs.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // short flash ops keep the run brief
  localparam int unsigned TICKS = 4;
  logic        mclk, rst_n, pwr_n, rc, eew, awv, awr, wv, wrd, bv, arv, arr, rv, frd, busy;
  logic [7:0]  awa, ara, flo, fhi, fdat, lkb;
  logic [5:0]  lpgm;
  logic [2:0]  awp, arp;
  logic [31:0] wd, rdat;
  logic [3:0]  ws;
  logic [1:0]  br, rr;
  logic [15:0] fadr;
  flr_pkg::flr_kind_t kind;
  int          fails, checked, ticks, cyc, lk, rds;
  logic [2:0]  rcs;

  flr_spm_ctrl #(.PROG_TICKS(TICKS)) dut (
    .MCLK_I(mclk), .RESET_N_I(rst_n), .PWR_RESET_N_I(pwr_n), .CE_I(1'b1),
    .AXI_AWVALID_I(awv), .AXI_AWREADY_O(awr), .AXI_AWADDR_I(awa), .AXI_AWPROT_I(awp),
    .AXI_WVALID_I(wv), .AXI_WREADY_O(wrd), .AXI_WDATA_I(wd), .AXI_WSTRB_I(ws),
    .AXI_BVALID_O(bv), .AXI_BREADY_I(1'b1), .AXI_BRESP_O(br),
    .AXI_ARVALID_I(arv), .AXI_ARREADY_O(arr), .AXI_ARADDR_I(ara), .AXI_ARPROT_I(arp),
    .AXI_RVALID_O(rv), .AXI_RREADY_I(1'b1), .AXI_RDATA_O(rdat), .AXI_RRESP_O(rr),
    .FUSE_LOW_PGM_I(flo), .FUSE_HIGH_PGM_I(fhi), .LOCK_PGM_I(lpgm), .RC_OSC_I(rc),
    .EEPROM_WRITE_ACTIVE_I(eew), .FLASH_DATA_I(fdat), .FLASH_RD_O(frd), .FLASH_ADDR_O(fadr),
    .FLASH_BUSY_O(busy), .FLASH_OP_KIND_O(kind), .LOCK_BITS_O(lkb));

  flr_cpu_model cpu (
    .clk_i(mclk), .awvalid_o(awv), .awready_i(awr), .awaddr_o(awa), .awprot_o(awp),
    .wvalid_o(wv), .wready_i(wrd), .wdata_o(wd), .wstrb_o(ws), .bvalid_i(bv), .bresp_i(br),
    .arvalid_o(arv), .arready_i(arr), .araddr_o(ara), .arprot_o(arp),
    .rvalid_i(rv), .rdata_i(rdat), .rresp_i(rr));

  // main clock, and an rc oscillator of unrelated phase
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  initial begin
    rc = 1'b0;
    forever #37 rc = ~rc;
  end

  // rc edges as the block sees them through a three-stage capture, counted while an op runs
  always @(posedge mclk) begin
    rcs <= {rcs[1:0], rc};
    if (busy === 1'b1 && rcs[1] === 1'b1 && rcs[2] === 1'b0) ticks++;
    if (frd === 1'b1) rds++;
  end

  // hang guard, well above the expected run length
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      wrap_up();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // expected readback byte, read sense inverted from the cell state
  function automatic logic [7:0] cfg_byte(input int p);
    if (p == 1) return 8'(lk);
    return (p == 0) ? ~flo : ~fhi;
  endfunction

  initial begin
    logic [31:0] v;
    logic [1:0]  r;
    logic [7:0]  src;
    int          p;
    void'($urandom(65));
    {rst_n, pwr_n, eew} = 3'b000;
    flo  = 8'($urandom);
    fhi  = 8'($urandom);
    lpgm = 6'($urandom);
    fdat = 8'($urandom);
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    pwr_n <= 1'b1;
    repeat (4) @(posedge mclk);
    lk = 32'hc0 | (~lpgm & 6'h3f);
    chk(32'(lkb), 32'(lk));
    // readback of every configuration byte
    for (int i = 0; i < 3; i++) begin
      p = (i == 2) ? 3 : i;
      cpu.wr(`FLR_ADDR_PTR, 32'(p), 4'hf, r);
      cpu.do_spm(8'h09, 16'h0001);
      cpu.rd(`FLR_ADDR_RESULT, v, r);
      chk(v, {22'h0, 2'b11, cfg_byte(p)});
      cpu.rd(`FLR_ADDR_CTRL, v, r);
      chk(v, 32'h0);
    end
    // load lands one cycle past the load window: plain read, then expiry
    cpu.wr(`FLR_ADDR_CTRL, 32'h9, 4'hf, r);
    cpu.wr(`FLR_ADDR_PTR, 32'h1, 4'hf, r);
    cpu.wr(`FLR_ADDR_CMD, 32'h1, 4'hf, r);
    chk(32'(fadr), 32'h1);
    cpu.rd(`FLR_ADDR_RESULT, v, r);
    chk(v, 32'h100 | 32'(fdat));
    cpu.rd(`FLR_ADDR_CTRL, v, r);
    chk(v, 32'h0);
    // load with both bits clear
    fdat <= 8'($urandom);
    cpu.wr(`FLR_ADDR_CMD, 32'h1, 4'hf, r);
    cpu.rd(`FLR_ADDR_RESULT, v, r);
    chk(v, 32'h100 | 32'(fdat));
    chk(32'(rds), 32'h2);
    // control write refused while eeprom busy
    eew <= 1'b1;
    cpu.wr(`FLR_ADDR_CTRL, 32'h9, 4'hf, r);
    cpu.rd(`FLR_ADDR_CTRL, v, r);
    chk(v, 32'h0);
    eew <= 1'b0;
    // unmapped offset answers with an error and no data
    cpu.wr(8'h14, 32'hffff_ffff, 4'hf, r);
    chk(32'(r), 32'(`FLR_RESP_SLVERR));
    cpu.rd(8'h14, v, r);
    chk({v[29:0], r}, 32'(`FLR_RESP_SLVERR));
    // lock write programs boot lock bits whose source bit is zero
    src = 8'($urandom) | 8'hc3;
    ticks = 0;
    // programming boot lock bits to block loader updates
    cpu.do_spm(8'h09, {src, 8'h02});
    lk = lk & src;
    cpu.wr(`FLR_ADDR_PTR, 32'h1, 4'hf, r);
    cpu.do_spm(8'h09, 16'h0001);
    cpu.rd(`FLR_ADDR_RESULT, v, r);
    chk(v, {22'h0, 2'b11, cfg_byte(1)});
    chk(32'(ticks), 32'(TICKS));
    // erase and write survive a system reset, then the section is re-enabled
    for (int k = 1; k < 3; k++) begin
      cpu.do_spm((k == 1) ? 8'h03 : 8'h05, 16'h0002);
      repeat (3) @(posedge mclk);
      chk(32'(kind), 32'(k));
      rst_n <= 1'b0;
      repeat (2) @(posedge mclk);
      rst_n <= 1'b1;
      @(posedge mclk);
      chk(32'(busy), 32'h1);
      cpu.rww_return();
      cpu.rd(`FLR_ADDR_CTRL, v, r);
      chk(v, 32'h0);
    end
    wrap_up();
  end
endmodule // tb_top
`default_nettype wire
